// File: verilog/flash2_pkg.sv
// constants for the second flash array access and protection block
package flash2_pkg;
  // register indices and byte addresses (byte address is four times the index)
  localparam logic [15:0] CTRL_IDX   = 16'hfe08;
  localparam logic [15:0] PROT_IDX   = 16'hff81;
  localparam logic [15:0] ADDR_IDX   = 16'hfe09;
  localparam logic [15:0] DATA_IDX   = 16'hfe0a;
  localparam logic [17:0] CTRL_ADDR  = {CTRL_IDX, 2'b00};
  localparam logic [17:0] PROT_ADDR  = {PROT_IDX, 2'b00};
  localparam logic [17:0] ADDR_ADDR  = {ADDR_IDX, 2'b00};
  localparam logic [17:0] DATA_ADDR  = {DATA_IDX, 2'b00};
  // control register bits
  localparam int B_PGM    = 0;
  localparam int B_ERASE  = 1;
  localparam int B_PERR   = 2;
  localparam int B_BUSY   = 3;
  localparam int B_SUSP   = 4;
  localparam int B_RERR   = 5;
  localparam int B_START  = 7;
  // user regions of the array
  localparam logic [15:0] R0_LO = 16'h0462;
  localparam logic [15:0] R0_HI = 16'h04ff;
  localparam logic [15:0] R1_LO = 16'h0980;
  localparam logic [15:0] R1_HI = 16'h1b7f;
  localparam logic [15:0] R2_LO = 16'h1e20;
  localparam logic [15:0] R2_HI = 16'h7fff;
  // protect start byte layout
  localparam logic [7:0] PROT_NONE = 8'hff;
  localparam int         PROT_LSB  = 7;
  // row and page geometry
  localparam int ROW_LSB  = 6;
  localparam int PAGE_LSB = 7;
  // timing
  localparam int CLK_NS        = 40;
  localparam int PGM_TIME_US   = 30;
  localparam int ERASE_TIME_US = 4000;
  localparam int PGM_CYC   = (PGM_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (ERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 17;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_SUSP = 3'b100
  } seq_t;
endpackage

// File: verilog/flash2_ctrl.sv
// second flash array controller: apb registers, protection and standby sequencing
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module flash2_ctrl #(
  parameter int ERASE_CYCLES = flash2_pkg::ERASE_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // low power modes and protect byte from the first array
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic [7:0]  protect_start_byte,
  // array macro
  output logic      [15:0] fl_addr,
  output logic      [7:0]  fl_wdata,
  output logic             fl_read,
  output logic             fl_pgm,
  output logic             fl_erase,
  output logic             fl_hv,
  input  wire logic [7:0]  fl_rdata
);

  typedef struct packed {
    flash2_pkg::seq_t              st;
    logic [flash2_pkg::CNT_W-1:0]  cnt;
    logic                          op_erase;
    logic                          perr;
    logic                          rerr;
    logic [15:0]                   addr;
    logic [7:0]                    wdata;
    logic [15:0]                   fl_addr;
    logic [7:0]                    fl_wdata;
    logic                          fl_read;
    logic                          fl_pgm;
    logic                          fl_erase;
    logic                          fl_hv;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } state_t;

  state_t s;
  state_t next_s;

  // inside one of the three user regions
  function automatic logic in_user(input logic [15:0] a);
    in_user = (a >= flash2_pkg::R0_LO && a <= flash2_pkg::R0_HI) ||
              (a >= flash2_pkg::R1_LO && a <= flash2_pkg::R1_HI) ||
              (a >= flash2_pkg::R2_LO && a <= flash2_pkg::R2_HI);
  endfunction

  // protection start from the protect byte
  // start bits placed
  logic [15:0] raw_start;
  logic [15:0] prot_start;
  logic        prot_on;
  assign raw_start = {1'b0, protect_start_byte, 7'h00};
  assign prot_on    = protect_start_byte != flash2_pkg::PROT_NONE;
  assign prot_start = (raw_start < flash2_pkg::R0_LO) ? flash2_pkg::R0_LO : raw_start;

  // bus decode
  logic        acc;
  logic        wr_done;
  logic        hit_ctrl;
  logic        hit_prot;
  logic        hit_addr;
  logic        hit_data;
  logic        mapped;
  logic        busy;
  logic        req_erase;
  logic        req_go;
  logic [15:0] chk_addr;
  logic [15:0] page_addr;
  logic        chk_user;
  logic        chk_prot;
  logic [7:0]  ctrl_rd;
  // a transfer completes in the cycle pready stands, so each write lands exactly once
  assign acc      = psel && penable && s.pready;
  assign wr_done  = acc && pwrite && !s.pslverr;
  assign hit_ctrl = paddr == flash2_pkg::CTRL_ADDR;
  assign hit_prot = paddr == flash2_pkg::PROT_ADDR;
  assign hit_addr = paddr == flash2_pkg::ADDR_ADDR;
  assign hit_data = paddr == flash2_pkg::DATA_ADDR;
  assign mapped   = hit_ctrl || hit_prot || hit_addr || hit_data;
  assign busy     = s.st != flash2_pkg::ST_IDLE;

  // request decode; erase wins when both bits are written
  // erase targets page base
  assign req_erase = pwdata[flash2_pkg::B_ERASE];
  assign req_go    = wr_done && hit_ctrl && pwdata[flash2_pkg::B_START] &&
                     (pwdata[flash2_pkg::B_PGM] || req_erase);
  assign page_addr = {s.addr[15:flash2_pkg::PAGE_LSB], 7'h00};
  // erase checks the page top so a partly protected page stays whole
  assign chk_addr  = req_erase ? {s.addr[15:flash2_pkg::PAGE_LSB], 7'h7f} : s.addr;
  assign chk_user  = in_user(req_erase ? page_addr | 16'h007f : s.addr);
  assign chk_prot  = prot_on && chk_addr >= prot_start;

  // status byte: range error, suspended, busy, protect error; request bits read zero
  assign ctrl_rd = {2'b00, s.rerr, s.st == flash2_pkg::ST_SUSP, busy, s.perr, 2'b00};

  // next state: bus, flags and sequencer
  always_comb
  begin
    next_s = s;
    next_s.pready  = psel && penable && !s.pready;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready)
    begin
      next_s.prdata = 32'h0000_0000;
      // no write path to protect byte
      next_s.pslverr = !mapped || (pwrite && hit_prot);
      if (!pwrite)
      begin
        if (hit_ctrl)
          next_s.prdata = {24'h00_0000, ctrl_rd};
        else if (hit_prot)
          next_s.prdata = {24'h00_0000, protect_start_byte};
        else if (hit_addr)
          next_s.prdata = {16'h0000, s.addr};
        // sense inverted: charged cell is zero
        else if (hit_data)
          next_s.prdata = {24'h00_0000, ~fl_rdata};
      end
    end
    if (wr_done && hit_addr && !busy)
      next_s.addr = pwdata[15:0];
    if (wr_done && hit_data && !busy)
      next_s.wdata = pwdata[7:0];
    // write one clears; a new error in the same write still sets
    if (wr_done && hit_ctrl && pwdata[flash2_pkg::B_PERR])
      next_s.perr = 1'b0;
    if (wr_done && hit_ctrl && pwdata[flash2_pkg::B_RERR])
      next_s.rerr = 1'b0;
    unique case (s.st)
      flash2_pkg::ST_IDLE:
      begin
        // read mode kept through wait or stop
        next_s.fl_read = 1'b1;
        next_s.fl_addr = s.addr;
        if (req_go)
        begin
          // refused requests leave the array alone
          if (!chk_user)
            next_s.rerr = 1'b1;
          else if (chk_prot)
            next_s.perr = 1'b1;
          else
          begin
            next_s.st       = flash2_pkg::ST_RUN;
            next_s.op_erase = req_erase;
            next_s.fl_addr  = req_erase ? page_addr : s.addr;
            next_s.fl_wdata = ~s.wdata;
            next_s.cnt      = req_erase ? flash2_pkg::CNT_W'(ERASE_CYCLES - 1) :
                                          flash2_pkg::CNT_W'(flash2_pkg::PGM_CYC - 1);
            next_s.fl_read  = 1'b0;
            next_s.fl_hv    = 1'b1;
            next_s.fl_pgm   = !req_erase;
            next_s.fl_erase = req_erase;
          end
        end
      end
      flash2_pkg::ST_RUN:
      begin
        if (wait_mode || stop_mode)
        begin
          next_s.st       = flash2_pkg::ST_SUSP;
          next_s.fl_hv    = 1'b0;
          next_s.fl_pgm   = 1'b0;
          next_s.fl_erase = 1'b0;
        end
        else if (s.cnt == '0)
        begin
          next_s.st       = flash2_pkg::ST_IDLE;
          next_s.fl_hv    = 1'b0;
          next_s.fl_pgm   = 1'b0;
          next_s.fl_erase = 1'b0;
          next_s.fl_read  = 1'b1;
          next_s.fl_addr  = s.addr;
        end
        else
          next_s.cnt = s.cnt - 1'b1;
      end
      flash2_pkg::ST_SUSP:
      begin
        next_s.fl_read = 1'b0;
        // remaining time resumes once both modes are left
        if (!wait_mode && !stop_mode)
        begin
          next_s.st       = flash2_pkg::ST_RUN;
          next_s.fl_hv    = 1'b1;
          next_s.fl_pgm   = !s.op_erase;
          next_s.fl_erase = s.op_erase;
        end
      end
      // an illegal code falls back to idle rather than lock the array up
      default:
        next_s.st = flash2_pkg::ST_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s          <= '0;
      s.st       <= flash2_pkg::ST_IDLE;
      s.fl_wdata <= 8'hff;
    end
    else
      s <= next_s;
  end

  // every output comes straight from the state register
  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pslverr  = s.pslverr;
  assign fl_addr  = s.fl_addr;
  assign fl_wdata = s.fl_wdata;
  assign fl_read  = s.fl_read;
  assign fl_pgm   = s.fl_pgm;
  assign fl_erase = s.fl_erase;
  assign fl_hv    = s.fl_hv;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  wait_suspend_a: assert property (s.st == flash2_pkg::ST_RUN && wait_mode |=>
    s.st == flash2_pkg::ST_SUSP && !fl_hv) else $error("wait did not suspend");
  stop_suspend_a: assert property (s.st == flash2_pkg::ST_RUN && stop_mode |=>
    s.st == flash2_pkg::ST_SUSP && !fl_pgm && !fl_erase) else $error("stop did not suspend");
  read_kept_a: assert property (s.st == flash2_pkg::ST_IDLE && (wait_mode || stop_mode)
    && !req_go |=> fl_read && s.st == flash2_pkg::ST_IDLE) else $error("read mode disturbed");
  standby_quiet_a: assert property (s.st == flash2_pkg::ST_SUSP |=>
    !fl_hv && !fl_pgm && !fl_erase && !fl_read || s.st == flash2_pkg::ST_RUN)
    else $error("array active in standby");
  read_back_a: assert property (pready && !pwrite && hit_data && !pslverr |->
    prdata[7:0] == ~$past(fl_rdata)) else $error("read polarity wrong");
  erase_page_a: assert property (fl_erase |-> fl_addr[6:0] == 7'h00)
    else $error("erase not page aligned");
  row_hold_a: assert property (fl_pgm && $past(fl_pgm) |-> $stable(fl_addr))
    else $error("program left its row");
  user_only_a: assert property (fl_pgm |-> in_user(fl_addr))
    else $error("program outside user space");
  prot_ro_a: assert property (pready && pwrite && hit_prot |-> pslverr)
    else $error("protect byte write accepted");
  prot_block_a: assert property (req_go && chk_user && chk_prot && !busy |=>
    s.perr && !fl_hv [*2]) else $error("protected request ran");
  prot_none_a: assert property (req_go && !busy && chk_user &&
    protect_start_byte == 8'hff |=> fl_hv) else $error("protection not disabled");
  prot_start_a: assert property (fl_pgm && prot_on |->
    fl_addr < prot_start) else $error("program inside protected range");

  // refusals, erase priority, the frozen count while in standby and the protect byte read
  range_block_a: assert property (req_go && !busy && !chk_user |=>
    s.rerr && !fl_hv) else $error("request outside user space ran");
  erase_wins_a: assert property (req_go && !busy && chk_user && !chk_prot &&
    req_erase |=> fl_erase && !fl_pgm) else $error("erase lost to program");
  susp_frozen_a: assert property (s.st == flash2_pkg::ST_SUSP |=>
    $stable(s.cnt)) else $error("count ran in standby");
  prot_read_a: assert property (pready && !pwrite && hit_prot && !pslverr |->
    prdata[7:0] == $past(protect_start_byte)) else $error("protect byte misread");

  // scenarios worth seeing at least once
  prog_run_c: cover property (fl_pgm ##1 !fl_hv && s.st == flash2_pkg::ST_IDLE);
  erase_susp_c: cover property (fl_erase ##1 s.st == flash2_pkg::ST_SUSP ##[1:20] fl_erase);
  prot_hit_c: cover property (req_go && chk_prot ##1 s.perr);
  range_hit_c: cover property (req_go && !chk_user ##1 s.rerr);
  erase_wins_c: cover property (req_go && req_erase && pwdata[flash2_pkg::B_PGM] ##1 fl_erase);

endmodule // flash2_ctrl

// File: verification/flash2_array_model.sv
// behavioural model of the second flash array macro
`timescale 1ns/1ns
module flash2_array_model (
  // clock
  input  wire logic        mclk,
  // array controls
  input  wire logic [15:0] fl_addr,
  input  wire logic [7:0]  fl_wdata,
  input  wire logic        fl_read,
  input  wire logic        fl_pgm,
  input  wire logic        fl_erase,
  input  wire logic        fl_hv,
  // raw sense, one marks a charged cell
  output logic      [7:0]  fl_rdata
);
  logic [7:0] cells [0:32767];
  logic [7:0] last;
  // every cell starts erased, so the bus reads ones
  initial
  begin
    for (int i = 0; i < 32768; i++) cells[i] = 8'h00;
    last = 8'h00;
  end
  // charge one byte or clear one whole page while pumped
  always @(posedge mclk)
  begin
    if (fl_hv && fl_pgm) cells[fl_addr[14:0]] <= cells[fl_addr[14:0]] | fl_wdata;
    if (fl_hv && fl_erase)
      for (int i = 0; i < 128; i++) cells[{fl_addr[14:7], i[6:0]}] <= 8'h00;
    if (fl_read) last <= cells[fl_addr[14:0]];
  end
  // sense is meaningless outside read mode, so show the inverse of the last byte
  assign fl_rdata = fl_read ? cells[fl_addr[14:0]] : ~last;
endmodule // flash2_array_model

// File: verification/flash_array_protect_standby_tb_top.sv
// self-checking bench for the second flash array controller
`timescale 1ns/1ns
module flash_array_protect_standby_tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic        pready, pslverr, e, wait_mode = 1'b0, stop_mode = 1'b0;
  logic [7:0]  protect_start_byte = 8'hff, fl_wdata, fl_rdata;
  logic [15:0] fl_addr;
  logic        fl_read, fl_pgm, fl_erase, fl_hv;
  int          errors = 0, n_compared = 0;
  // psb, address, data, control, expected control, expected byte afterwards
  localparam logic [55:0] CASES [10] = '{56'h20_1000_0081_04ff, 56'h21_1080_0082_0400,
    56'h00_0462_0081_04ff, 56'hfe_7f00_0081_04ff, 56'hfe_7eff_5a81_005a,
    56'hff_7fff_c381_00c3, 56'hff_0500_0081_20ff, 56'hff_04ff_1181_0011,
    56'h09_047f_7781_0077, 56'h09_0480_0081_04ff};
  // 25 MHz bus clock
  always #20 mclk = ~mclk;
  // controller and the array it drives
  flash2_ctrl #(.ERASE_CYCLES(20)) u_flash2_ctrl (.mclk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .protect_start_byte,
    .fl_addr, .fl_wdata, .fl_read, .fl_pgm, .fl_erase, .fl_hv, .fl_rdata);
  flash2_array_model u_flash2_array_model (.mclk, .fl_addr, .fl_wdata, .fl_read, .fl_pgm,
    .fl_erase, .fl_hv, .fl_rdata);
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      $display("BAD %0t bus transfer got no answer", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [17:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk({e, r}, exp);
  endtask
  // point the address register at a byte and read it back
  task automatic peek(input logic [15:0] a, input logic [7:0] exp);
    apb(1'b1, flash2_pkg::ADDR_ADDR, {16'h0000, a});
    rdchk(flash2_pkg::DATA_ADDR, 33'(exp));
  endtask
  task automatic go(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    apb(1'b1, flash2_pkg::ADDR_ADDR, {16'h0000, a});
    apb(1'b1, flash2_pkg::DATA_ADDR, {24'h00_0000, d});
    apb(1'b1, flash2_pkg::CTRL_ADDR, {24'h00_0000, c});
  endtask
  // poll busy under a bound; a slow program takes about two hundred polls
  task automatic finish;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, flash2_pkg::CTRL_ADDR, 32'h0000_0000);
      n++;
    end
    while (r[flash2_pkg::B_BUSY] !== 1'b0 && n < 400);
    if (r[flash2_pkg::B_BUSY] !== 1'b0)
    begin
      errors++;
      $display("BAD %0t operation never finished", $time);
    end
  endtask
  task automatic t_regs;
    rdchk(flash2_pkg::CTRL_ADDR, 33'h0_0000_0000);
    rdchk(flash2_pkg::PROT_ADDR, 33'h0_0000_00ff);
    apb(1'b1, flash2_pkg::PROT_ADDR, 32'h0000_0000);
    chk(33'(e), 33'h0_0000_0001);
    rdchk(flash2_pkg::PROT_ADDR, 33'h0_0000_00ff);
    rdchk(18'h0_0100, 33'h1_0000_0000);
  endtask
  task automatic t_prog;
    peek(16'h1000, 8'hff);
    go(16'h1000, 8'ha5, 8'h81);
    finish;
    chk(33'(r), 33'h0_0000_0000);
    peek(16'h1000, 8'ha5);
    peek(16'h0fff, 8'hff);
  endtask
  // a mode raised mid-program must freeze it; the program resumes on release
  task automatic t_standby;
    for (int i = 0; i < 2; i++)
    begin
      go(16'h1001 + 16'(i), 8'h3c, 8'h81);
      repeat (5) @(posedge mclk);
      wait_mode <= (i == 0);
      stop_mode <= (i == 1);
      repeat (3) @(posedge mclk);
      chk(33'({fl_hv, fl_pgm, fl_erase, fl_read}), 33'h0_0000_0000);
      repeat (800) @(posedge mclk);
      rdchk(flash2_pkg::CTRL_ADDR, 33'h0_0000_0018);
      wait_mode <= 1'b0;
      stop_mode <= 1'b0;
      finish;
      peek(16'h1001 + 16'(i), 8'h3c);
    end
  endtask
  // modes raised only once no operation runs
  task automatic t_idle;
    wait_mode <= 1'b1;
    stop_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(33'({fl_read, fl_hv}), 33'h0_0000_0002);
    rdchk(flash2_pkg::DATA_ADDR, 33'h0_0000_003c);
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
  endtask
  task automatic t_erase;
    go(16'h1080, 8'h00, 8'h81);
    finish;
    go(16'h1040, 8'h00, 8'h82);
    finish;
    peek(16'h1000, 8'hff);
    peek(16'h107f, 8'hff);
    peek(16'h1080, 8'h00);
    go(16'h1100, 8'h00, 8'h81);
    finish;
    go(16'h1100, 8'h0f, 8'h83);
    finish;
    peek(16'h1100, 8'hff);
  endtask
  task automatic t_prot;
    foreach (CASES[i])
    begin
      protect_start_byte <= CASES[i][55:48];
      go(CASES[i][47:32], CASES[i][31:24], CASES[i][23:16]);
      finish;
      chk(33'(r), 33'(CASES[i][15:8]));
      peek(CASES[i][47:32], CASES[i][7:0]);
      apb(1'b1, flash2_pkg::CTRL_ADDR, 32'h0000_0024);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence after five reset cycles
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_prog;
    t_standby;
    t_idle;
    t_erase;
    t_prot;
    complete_run;
  end
  // watchdog, well beyond the roughly ten thousand cycles the tests need
  initial
  begin
    #2000000;
    errors++;
    complete_run;
  end
endmodule // flash_array_protect_standby_tb_top
